/* logic/meas_cmd_consts.svh */
/*
  constants for the measurement command decoder: command codes, memory words,
  status bit positions, counts.
  assumes inclusion by bare name from the design files.
*/
`ifndef MEAS_CMD_CONSTS_SVH
`define MEAS_CMD_CONSTS_SVH

`define CMD_RAW_BASE 8'ha0
`define CMD_RAW_MASK 8'hf8
`define CMD_AVG2 8'hac
`define CMD_AVG4 8'had
`define CMD_AVG8 8'hae
`define CMD_AVG16 8'haf
`define CMD_SEL_PRIMARY 8'hb0
`define CMD_SEL_SECONDARY 8'hb1
`define CMD_HALT 8'hbf
`define CMD_POLL_NIBBLE 4'hf
`define ADDR_PRIMARY_SETUP 6'h12
`define ADDR_SECONDARY_SETUP 6'h16
`define ST_BUSY 5
`define ST_SETUP_SEL 1
`define RAW_TEMP_BIT 2
`define RAW_AZ_BIT 1
`define RAW_HOST_BIT 0
`define TEMP_KEEP_MASK 16'h1fff
`define LOG2_AVG2 3'h1
`define LOG2_AVG4 3'h2
`define LOG2_AVG8 3'h3
`define LOG2_AVG16 3'h4
`define ONE_SAMPLE 5'h01

`endif

/* logic/meas_cmd_pkg.sv */
/*
  types for the measurement command decoder.
  assumes nothing beyond a SystemVerilog compiler.
*/
package meas_cmd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_START = 3'b010,
    ST_WAIT = 3'b011,
    ST_DONE = 3'b100
  } dec_state_type;

  typedef enum logic [1:0] {
    KIND_SENSOR = 2'b00,
    KIND_AZ_SENSOR = 2'b01,
    KIND_TEMP = 2'b10,
    KIND_AZ_TEMP = 2'b11
  } meas_kind_type;
endpackage

/* logic/cmd_classify.sv */
/*
  combinational classification of a command byte.
  assumes the byte is stable while cmd_valid is high in the caller.
*/
`timescale 1ns/1ps
`include "meas_cmd_consts.svh"

module cmd_classify
(
  input wire logic [7:0] cmd_i,
  output logic is_raw_o,
  output logic is_avg_o,
  output logic [2:0] avg_log2_o,
  output logic is_sel1_o,
  output logic is_sel2_o,
  output logic is_halt_o,
  output logic is_poll_o
);
  always_comb
  begin
    is_raw_o = (cmd_i & `CMD_RAW_MASK) == `CMD_RAW_BASE;
    is_sel1_o = cmd_i == `CMD_SEL_PRIMARY;
    is_sel2_o = cmd_i == `CMD_SEL_SECONDARY;
    is_halt_o = cmd_i == `CMD_HALT;
    is_poll_o = cmd_i[7:4] == `CMD_POLL_NIBBLE;
    is_avg_o = 1'b1;
    case (cmd_i)
      `CMD_AVG2: avg_log2_o = `LOG2_AVG2;
      `CMD_AVG4: avg_log2_o = `LOG2_AVG4;
      `CMD_AVG8: avg_log2_o = `LOG2_AVG8;
      `CMD_AVG16: avg_log2_o = `LOG2_AVG16;
      default:
      begin
        avg_log2_o = 3'h0;
        is_avg_o = 1'b0;
      end
    endcase
  end
endmodule // cmd_classify

/* logic/avg_accum.sv */
/*
  accumulator for averaged measurements: sums sensor and temperature results
  and divides by a power of two with a right shift.
  assumes clear and add are never high together.
*/
`timescale 1ns/1ps

module avg_accum #(
  parameter int DATA_W = 24,
  parameter int SUM_W = 28
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic add_i,
  input wire logic [DATA_W-1:0] sens_i,
  input wire logic [DATA_W-1:0] temp_i,
  input wire logic [2:0] log2_i,
  output logic [DATA_W-1:0] sens_avg_o,
  output logic [DATA_W-1:0] temp_avg_o
);
  logic [SUM_W-1:0] sens_sum_r;
  logic [SUM_W-1:0] temp_sum_r;
  logic [SUM_W-1:0] sens_shift;
  logic [SUM_W-1:0] temp_shift;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sens_sum_r <= '0;
      temp_sum_r <= '0;
    end
    else if (clear_i)
    begin
      sens_sum_r <= '0;
      temp_sum_r <= '0;
    end
    else if (add_i)
    begin
      sens_sum_r <= sens_sum_r + SUM_W'(sens_i);
      temp_sum_r <= temp_sum_r + SUM_W'(temp_i);
    end
  end

  always_comb
  begin
    sens_shift = sens_sum_r >> log2_i;
    temp_shift = temp_sum_r >> log2_i;
    sens_avg_o = sens_shift[DATA_W-1:0];
    temp_avg_o = temp_shift[DATA_W-1:0];
  end
endmodule // avg_accum

/* logic/measurement_command_decoder.sv */
/*
  measurement command decoder: averaged full measurements, setup selection,
  halt of cyclic operation, status poll and raw measurements.
  assumes an interface front end that hands over a command byte with its
  16-bit data word, a memory read port for the setup words, and a
  measurement engine with start/done handshake.
*/
// Overview of operation
// - command ac runs two full measurements back to back and stores their mean.
// - command ad runs four full measurements back to back and stores their mean.
// - command ae runs eight full measurements back to back and stores their mean.
// - command af runs sixteen full measurements and returns 24-bit averaged results.
// - command b0 selects the setup at memory word 12h and clears status bit 1 (default).
// - command b1 selects the setup at memory word 16h and sets status bit 1.
// - command bf powers the path down, stops cyclic operation, enters sleep, any mode.
// - a byte with upper nibble f is a poll returning status and last result, spi only.
// - raw a0 and a2 measure the sensor with the selected stored setup, a2 with auto-zero.
// - odd raw commands use the host-supplied 16-bit word instead of the stored setup.
// - raw a4 and a6 measure temperature with a fixed internal setup, a6 with auto-zero.
// - on a5 and a7 bits 15 to 13 of the host word are ignored.
// - raw commands a0 to a7 put the unconditioned 24-bit result in the output register.
// - while a command executes, status bit 5 shows busy and new commands are ignored.
`timescale 1ns/1ps
`include "meas_cmd_consts.svh"

module measurement_command_decoder
  import meas_cmd_pkg::*;
#(
  parameter int DATA_W = 24,
  parameter logic [15:0] TEMP_SETUP = 16'h0000
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_i,
  input wire logic [15:0] cmd_data_i,
  input wire logic spi_mode_i,
  output logic [5:0] mem_addr_o,
  output logic mem_rd_o,
  input wire logic [15:0] mem_rdata_i,
  input wire logic mem_rvalid_i,
  output logic meas_start_o,
  output logic meas_full_o,
  output logic [1:0] meas_kind_o,
  output logic [15:0] meas_setup_o,
  input wire logic meas_done_i,
  input wire logic [DATA_W-1:0] meas_sens_i,
  input wire logic [DATA_W-1:0] meas_temp_i,
  output logic halt_o,
  output logic busy_o,
  output logic setup_sel_o,
  output logic [DATA_W-1:0] result_sens_o,
  output logic [DATA_W-1:0] result_temp_o,
  output logic result_valid_o,
  output logic poll_o
);
  dec_state_type state_r;
  logic sel_secondary_r;
  logic [7:0] cur_cmd_r;
  logic [15:0] setup_r;
  logic [4:0] remain_r;
  logic [2:0] log2_r;
  logic avg_mode_r;
  logic meas_start_r;
  logic halt_r;
  logic poll_r;
  logic [DATA_W-1:0] res_sens_r;
  logic [DATA_W-1:0] res_temp_r;
  logic res_valid_r;
  logic is_raw;
  logic is_avg;
  logic [2:0] avg_log2;
  logic is_sel1;
  logic is_sel2;
  logic is_halt;
  logic is_poll;
  logic accept;
  logic acc_clear;
  logic acc_add;
  logic [DATA_W-1:0] sens_avg;
  logic [DATA_W-1:0] temp_avg;

  function automatic logic [15:0] raw_setup(input logic [7:0] cmd, input logic [15:0] word);
    if (cmd[`RAW_TEMP_BIT])
      raw_setup = word & `TEMP_KEEP_MASK;
    else
      raw_setup = word;
  endfunction

  // end of one measurement sample
  function automatic logic sample_end(input dec_state_type st, input logic done);
    sample_end = (st == ST_WAIT) && done;
  endfunction

  cmd_classify u_classify
  (
    .cmd_i(cmd_i),
    .is_raw_o(is_raw),
    .is_avg_o(is_avg),
    .avg_log2_o(avg_log2),
    .is_sel1_o(is_sel1),
    .is_sel2_o(is_sel2),
    .is_halt_o(is_halt),
    .is_poll_o(is_poll)
  );

  avg_accum #(
    .DATA_W(DATA_W),
    .SUM_W(DATA_W + 4)
  ) u_accum
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(acc_clear),
    .add_i(acc_add),
    .sens_i(meas_sens_i),
    .temp_i(meas_temp_i),
    .log2_i(log2_r),
    .sens_avg_o(sens_avg),
    .temp_avg_o(temp_avg)
  );

  // commands only taken while idle
  assign accept = cmd_valid_i && (state_r == ST_IDLE);
  assign acc_clear = accept && is_avg;
  assign acc_add = sample_end(state_r, meas_done_i) && avg_mode_r;

  // command state machine
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_r <= ST_IDLE;
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (accept && is_avg)
            state_r <= ST_START;
          else if (accept && is_raw && !cmd_i[`RAW_HOST_BIT] && !cmd_i[`RAW_TEMP_BIT])
            state_r <= ST_FETCH;
          else if (accept && is_raw)
            state_r <= ST_START;
        end
        ST_FETCH:
        begin
          if (mem_rvalid_i)
            state_r <= ST_START;
        end
        ST_START:
          state_r <= ST_WAIT;
        ST_WAIT:
        begin
          // next sample goes back through ST_START, its start pulse two cycles after done
          if (meas_done_i)
            state_r <= (remain_r == `ONE_SAMPLE) ? ST_DONE : ST_START;
        end
        ST_DONE:
          state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // command byte and averaging depth held for the whole command
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cur_cmd_r <= 8'h00;
      avg_mode_r <= 1'b0;
      log2_r <= 3'h0;
    end
    else if (accept && is_avg)
    begin
      cur_cmd_r <= cmd_i;
      avg_mode_r <= 1'b1;
      log2_r <= avg_log2;
    end
    else if (accept && is_raw)
    begin
      cur_cmd_r <= cmd_i;
      avg_mode_r <= 1'b0;
      log2_r <= 3'h0;
    end
  end

  // samples still to run for the current command
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      remain_r <= 5'h00;
    else if (accept && is_avg)
      remain_r <= 5'(`ONE_SAMPLE << avg_log2);
    else if (accept && is_raw)
      remain_r <= `ONE_SAMPLE;
    else if (sample_end(state_r, meas_done_i))
      remain_r <= remain_r - `ONE_SAMPLE;
  end

  // measurement setup word
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      setup_r <= 16'h0000;
    else if (accept && is_raw && cmd_i[`RAW_HOST_BIT])
      setup_r <= raw_setup(cmd_i, cmd_data_i);
    else if (accept && is_raw && cmd_i[`RAW_TEMP_BIT])
      setup_r <= TEMP_SETUP;
    else if ((state_r == ST_FETCH) && mem_rvalid_i)
      setup_r <= mem_rdata_i;
  end

  // setup selection
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sel_secondary_r <= 1'b0;
    else if (accept && is_sel1)
      sel_secondary_r <= 1'b0;
    else if (accept && is_sel2)
      sel_secondary_r <= 1'b1;
  end

  // start pulse for the engine
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      meas_start_r <= 1'b0;
    else
      meas_start_r <= (state_r == ST_START);
  end

  // halt pulse
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      halt_r <= 1'b0;
    else
      halt_r <= accept && is_halt;
  end

  // poll pulse, spi only
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      poll_r <= 1'b0;
    else
      poll_r <= accept && is_poll && spi_mode_i;
  end

  // result data
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      res_sens_r <= '0;
      res_temp_r <= '0;
    end
    else if (state_r == ST_DONE && avg_mode_r)
    begin
      res_sens_r <= sens_avg;
      res_temp_r <= temp_avg;
    end
    else if (sample_end(state_r, meas_done_i) && !avg_mode_r)
    begin
      res_sens_r <= cur_cmd_r[`RAW_TEMP_BIT] ? meas_temp_i : meas_sens_i;
      res_temp_r <= '0;
    end
  end

  // result valid: any accepted command but a poll drops it
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      res_valid_r <= 1'b0;
    else if (state_r == ST_DONE && avg_mode_r)
      res_valid_r <= 1'b1;
    else if (sample_end(state_r, meas_done_i) && !avg_mode_r)
      res_valid_r <= 1'b1;
    else if (accept && !is_poll)
      res_valid_r <= 1'b0;
  end

  always_comb
  begin
    mem_rd_o = (state_r == ST_FETCH);
    mem_addr_o = sel_secondary_r ? `ADDR_SECONDARY_SETUP : `ADDR_PRIMARY_SETUP;
    meas_start_o = meas_start_r;
    meas_full_o = avg_mode_r;
    meas_kind_o = cur_cmd_r[`RAW_TEMP_BIT:`RAW_AZ_BIT];
    meas_setup_o = setup_r;
    halt_o = halt_r;
    busy_o = (state_r != ST_IDLE);
    setup_sel_o = sel_secondary_r;
    result_sens_o = res_sens_r;
    result_temp_o = res_temp_r;
    result_valid_o = res_valid_r;
    poll_o = poll_r;
  end
endmodule // measurement_command_decoder

/* verification/meas_cmd_properties.sv */
/* port checks for the measurement command decoder.
   assumes binding to measurement_command_decoder. */
`timescale 1ns/1ps
`include "meas_cmd_consts.svh"
module meas_cmd_properties
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_i,
  input wire logic spi_mode_i,
  input wire logic [5:0] mem_addr_o,
  input wire logic meas_start_o,
  input wire logic meas_full_o,
  input wire logic [15:0] meas_setup_o,
  input wire logic meas_done_i,
  input wire logic halt_o,
  input wire logic busy_o,
  input wire logic setup_sel_o,
  input wire logic result_valid_o,
  input wire logic poll_o
);
  logic acc;
  assign acc = cmd_valid_i && !busy_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_HALT: assert property (acc && cmd_i == `CMD_HALT |=> halt_o ##1 !halt_o)
    else $error("halt pulse wrong");
  AST_REFUSE: assert property (busy_o && cmd_valid_i |=> !halt_o && !poll_o)
    else $error("command taken while busy");
  AST_POLL: assert property (acc && cmd_i[7:4] == `CMD_POLL_NIBBLE |=>
    poll_o == $past(spi_mode_i))
    else $error("poll pulse wrong");
  AST_SEL2: assert property (acc && cmd_i == `CMD_SEL_SECONDARY |=>
    setup_sel_o && !busy_o)
    else $error("secondary select wrong");
  AST_SEL1: assert property (acc && cmd_i == `CMD_SEL_PRIMARY |=> !setup_sel_o)
    else $error("primary select wrong");
  AST_ADDR: assert property (mem_addr_o ==
    (setup_sel_o ? `ADDR_SECONDARY_SETUP : `ADDR_PRIMARY_SETUP))
    else $error("setup address wrong");
  AST_TEMP: assert property (acc && (cmd_i & 8'hfd) == 8'ha5 |-> ##2 meas_start_o
    && meas_setup_o[15:13] == 3'h0)
    else $error("host temp setup wrong");
  AST_AVG: assert property (acc && cmd_i[7:2] == 6'h2b |=> busy_o ##1
    meas_start_o && meas_full_o)
    else $error("average start wrong");
  AST_RAWRES: assert property (busy_o && !meas_full_o && meas_done_i |=>
    result_valid_o)
    else $error("raw result missing");
  AST_STARTBUSY: assert property (meas_start_o |-> busy_o)
    else $error("start without busy");
  cover property (acc && cmd_i == `CMD_AVG16);
  cover property (poll_o);
  cover property (halt_o);
endmodule // meas_cmd_properties
bind measurement_command_decoder meas_cmd_properties meas_cmd_properties_inst (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
  .spi_mode_i(spi_mode_i), .mem_addr_o(mem_addr_o), .meas_start_o(meas_start_o),
  .meas_full_o(meas_full_o), .meas_setup_o(meas_setup_o), .meas_done_i(meas_done_i),
  .halt_o(halt_o), .busy_o(busy_o), .setup_sel_o(setup_sel_o),
  .result_valid_o(result_valid_o), .poll_o(poll_o));

/* verification/meas_partner.sv */
/* setup memory and measurement engine model.
   assumes the decoder's memory and engine ports. */
`timescale 1ns/1ps
module meas_partner #(
  parameter logic [15:0] P1 = 16'h1357,
  parameter logic [15:0] P2 = 16'h2468
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] lat_i,
  input wire logic mem_rd_i,
  input wire logic [5:0] mem_addr_i,
  output logic [15:0] mem_rdata_o,
  output logic mem_rvalid_o,
  input wire logic meas_start_i,
  input wire logic meas_full_i,
  input wire logic [1:0] meas_kind_i,
  input wire logic [15:0] meas_setup_i,
  output logic meas_done_o,
  output logic [23:0] meas_sens_o,
  output logic [23:0] meas_temp_o
);
  logic [2:0] mc;
  logic [3:0] ec;
  logic rv, dn;
  logic [23:0] s_r, t_r, sv, tv;
  logic [15:0] setup_seen;
  logic [1:0] kind_seen;
  logic full_seen;
  logic [23:0] sq[$];
  logic [23:0] tq[$];
  logic [15:0] word;
  assign word = (mem_addr_i == 6'h12) ? P1 : P2;
  assign mem_rdata_o = rv ? word : ~word;
  assign mem_rvalid_o = rv;
  assign meas_done_o = dn;
  assign meas_sens_o = dn ? s_r : ~s_r;
  assign meas_temp_o = dn ? t_r : ~t_r;
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rv <= 0;
      dn <= 0;
      mc <= 0;
      ec <= 0;
    end
    else
    begin
      rv <= 0;
      dn <= 0;
      if (!rv && mem_rd_i)
      begin
        if (mc == lat_i)
        begin
          rv <= 1;
          mc <= 0;
        end
        else
          mc <= mc + 3'h1;
      end
      if (meas_start_i)
      begin
        ec <= {1'b0, lat_i} + 4'h1;
        setup_seen <= meas_setup_i;
        kind_seen <= meas_kind_i;
        full_seen <= meas_full_i;
      end
      else if (ec != 0)
      begin
        ec <= ec - 4'h1;
        if (ec == 1)
        begin
          sv = 24'($urandom);
          tv = 24'($urandom);
          sq.push_back(sv);
          tq.push_back(tv);
          s_r <= sv;
          t_r <= tv;
          dn <= 1;
        end
      end
    end
  end
endmodule // meas_partner

/* verification/testbench.sv */
/* self-checking bench for the measurement command decoder.
   assumes the partner model and the bound checker. */
`timescale 1ns/1ps
module testbench;
  import meas_cmd_pkg::*;
  localparam logic [15:0] TSET = 16'h5a5a;
  logic clk_i = 0, rst_n_i = 0, cmd_valid_i = 0, spi_mode_i = 0;
  logic [7:0] cmd_i = 0;
  logic [15:0] cmd_data_i = 0, mem_rdata_i, meas_setup_o, d, e;
  logic [2:0] lat_i = 1;
  logic [5:0] mem_addr_o;
  logic [1:0] meas_kind_o;
  logic mem_rd_o, mem_rvalid_i, meas_start_o, meas_full_o, meas_done_i;
  logic halt_o, busy_o, setup_sel_o, result_valid_o, poll_o;
  logic [23:0] meas_sens_i, meas_temp_i, result_sens_o, result_temp_o, keep;
  logic [7:0] c;
  int n_mismatch = 0, total_checks = 0, q0;
  longint ss, st;
  always #4 clk_i = ~clk_i;
  measurement_command_decoder #(.TEMP_SETUP(TSET)) measurement_command_decoder_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .cmd_data_i(cmd_data_i), .spi_mode_i(spi_mode_i), .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o), .mem_rdata_i(mem_rdata_i), .mem_rvalid_i(mem_rvalid_i),
    .meas_start_o(meas_start_o), .meas_full_o(meas_full_o), .meas_kind_o(meas_kind_o),
    .meas_setup_o(meas_setup_o), .meas_done_i(meas_done_i), .meas_sens_i(meas_sens_i),
    .meas_temp_i(meas_temp_i), .halt_o(halt_o), .busy_o(busy_o),
    .setup_sel_o(setup_sel_o), .result_sens_o(result_sens_o),
    .result_temp_o(result_temp_o), .result_valid_o(result_valid_o), .poll_o(poll_o));
  meas_partner meas_partner_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .lat_i(lat_i),
    .mem_rd_i(mem_rd_o),
    .mem_addr_i(mem_addr_o), .mem_rdata_o(mem_rdata_i), .mem_rvalid_o(mem_rvalid_i),
    .meas_start_i(meas_start_o), .meas_full_i(meas_full_o), .meas_kind_i(meas_kind_o),
    .meas_setup_i(meas_setup_o), .meas_done_o(meas_done_i), .meas_sens_o(meas_sens_i),
    .meas_temp_o(meas_temp_i));
  task chk(string nm, logic [23:0] x, logic [23:0] g);
    total_checks++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task drive(logic [7:0] k, logic [15:0] w);
    @(posedge clk_i);
    #1 cmd_i = k;
    cmd_data_i = w;
    cmd_valid_i = 1;
    @(posedge clk_i);
    #1 cmd_valid_i = 0;
  endtask
  task idle;
    for (int k = 0; k < 2000 && busy_o !== 1'b0; k++)
      @(posedge clk_i) #1;
  endtask
  task raw_all(logic sel);
    for (int i = 0; i < 8; i++)
    begin
      c = 8'ha0 + 8'(i);
      d = c[0] ? 16'($urandom) : 16'h0000;
      lat_i = 3'($urandom_range(0, 5));
      e = c[0] ? (c[2] ? d & 16'h1fff : d) : (c[2] ? TSET : (sel ? 16'h2468 : 16'h1357));
      idle;
      drive(c, d);
      idle;
      chk("kind", 24'(c[2:1]), 24'(meas_partner_inst.kind_seen));
      chk("setup", 24'(e), 24'(meas_partner_inst.setup_seen));
      chk("full", 24'h0, 24'(meas_partner_inst.full_seen));
      keep = c[2] ? meas_partner_inst.tq[$] : meas_partner_inst.sq[$];
      chk("raw", keep, result_sens_o);
      chk("raw_temp", 24'h0, result_temp_o);
      chk("valid", 24'h1, 24'(result_valid_o));
    end
    $display("test raw done");
  endtask
  initial
  begin
    void'($urandom(32'hefc22ee9));
    repeat (2) @(posedge clk_i);
    #1 rst_n_i = 1;
    chk("sel", 24'h0, 24'(setup_sel_o));
    chk("addr", 24'h12, 24'(mem_addr_o));
    raw_all(0);
    drive(8'hb1, 16'h0000);
    chk("sel", 24'h1, 24'(setup_sel_o));
    chk("addr", 24'h16, 24'(mem_addr_o));
    chk("valid", 24'h0, 24'(result_valid_o));
    raw_all(1);
    drive(8'hb0, 16'h0000);
    chk("sel", 24'h0, 24'(setup_sel_o));
    chk("addr", 24'h12, 24'(mem_addr_o));
    for (int k = 0; k < 4; k++)
    begin
      q0 = meas_partner_inst.sq.size();
      idle;
      drive(8'hac + 8'(k), 16'h0000);
      idle;
      chk("count", 24'(2 << k), 24'(meas_partner_inst.sq.size() - q0));
      chk("full", 24'h1, 24'(meas_partner_inst.full_seen));
      ss = 0;
      st = 0;
      for (int j = q0; j < meas_partner_inst.sq.size(); j++)
      begin
        ss += meas_partner_inst.sq[j];
        st += meas_partner_inst.tq[j];
      end
      chk("avg_sens", 24'(ss >> (k + 1)), result_sens_o);
      chk("avg_temp", 24'(st >> (k + 1)), result_temp_o);
    end
    $display("test average done");
    keep = result_sens_o;
    spi_mode_i = 1;
    drive(8'hf3, 16'h0000);
    chk("poll", 24'h1, 24'(poll_o));
    chk("kept", keep, result_sens_o);
    chk("valid", 24'h1, 24'(result_valid_o));
    spi_mode_i = 0;
    drive(8'hf0, 16'h0000);
    chk("poll", 24'h0, 24'(poll_o));
    $display("test poll done");
    drive(8'had, 16'h0000);
    drive(8'hbf, 16'h0000);
    chk("halt", 24'h0, 24'(halt_o));
    idle;
    drive(8'hbf, 16'h0000);
    chk("halt", 24'h1, 24'(halt_o));
    $display("test halt done");
    print_verdict;
  end
  initial
  begin
    repeat (50000) @(posedge clk_i);
    n_mismatch++;
    print_verdict;
  end
endmodule // testbench
